/* lxb_pkg.sv */
/*
 * lxb_pkg: constants shared by the expanded configuration bank of the
 * octal line interface and its in-band loopback code detector.
 * Assumes an 8-bit host register port and a 100 MHz system clock.
 */
package lxb_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int LXB_CHANNELS = 8;
	localparam int LXB_DW = 8;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] LXB_OFF_RX_PD = 8'h03;
	localparam logic [7:0] LXB_OFF_TX_PD = 8'h04;
	localparam logic [7:0] LXB_OFF_ZERO_RUN = 8'h05;
	localparam logic [7:0] LXB_OFF_VIOL_DIS = 8'h06;
	localparam logic [7:0] LXB_OFF_TERM_SEL = 8'h07;
	localparam logic [7:0] LXB_OFF_LOOP_CFG = 8'h08;
	localparam logic [7:0] LXB_OFF_ACT_PAT = 8'h09;
	localparam logic [7:0] LXB_OFF_DEACT_PAT = 8'h0A;
	localparam logic [7:0] LXB_OFF_LOOP_STAT = 8'h0B;
	localparam logic [7:0] LXB_OFF_LOOP_MASK = 8'h0C;
	localparam logic [7:0] LXB_OFF_LOOP_INT = 8'h0D;
	localparam logic [7:0] LXB_OFF_BANK_PTR = 8'h1F;

	// ----------------------------------------------------------------
	// values, fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] LXB_BANK_PRIMARY = 8'h00;
	localparam logic [7:0] LXB_BANK_EXPANDED = 8'hAA;
	localparam logic [7:0] LXB_RST_BYTE = 8'h00;
	localparam logic [7:0] LXB_CFG_WR_MASK = 8'h3F;
	localparam int LXB_CFG_DET_BIT = 5;
	localparam int LXB_CFG_AUTO_BIT = 4;
	localparam int LXB_CFG_ALEN_LSB = 2;
	localparam int LXB_CFG_DLEN_LSB = 0;
	localparam int LXB_CODE_MIN_LEN = 5;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int LXB_CLK_NS = 10;
	localparam int LXB_TCLK_LOW_NS = 1000;
	localparam int LXB_TCLK_LOW_CYC =
		(LXB_TCLK_LOW_NS + LXB_CLK_NS - 1) / LXB_CLK_NS;
	localparam int LXB_MATCH_RUN = 32;

endpackage : lxb_pkg

/* lxb_det_if.sv */
/*
 * lxb_det_if: carries loopback code configuration from the bank to the
 * detector and the per-channel hit flags back.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
interface lxb_det_if;
	logic det_enable;
	logic [7:0] act_pattern;
	logic [7:0] deact_pattern;
	logic [1:0] act_len;
	logic [1:0] deact_len;
	logic [7:0] rx_bit;
	logic [7:0] rx_bit_valid;
	logic [7:0] act_hit;
	logic [7:0] deact_hit;

	modport bank (output det_enable, act_pattern, deact_pattern, act_len,
		deact_len, rx_bit, rx_bit_valid, input act_hit, deact_hit);
	modport det (input det_enable, act_pattern, deact_pattern, act_len,
		deact_len, rx_bit, rx_bit_valid, output act_hit, deact_hit);
endinterface : lxb_det_if

/* lxb_code_detect.sv */
/*
 * lxb_code_detect: per-channel in-band loopback code detector.
 * Assumes decoded receive bits arrive on the system clock with a
 * one-cycle valid strobe per bit, oldest bit first.
 */
`timescale 1ns/1ns
module lxb_code_detect import lxb_pkg::*; #(
	parameter int CHANNELS = LXB_CHANNELS,
	parameter int RUN_BITS = LXB_MATCH_RUN
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// configuration and hits
	lxb_det_if.det det
);
	localparam int RUN_W = $clog2(RUN_BITS + 1);
	localparam logic [RUN_W-1:0] RUN_MAX = RUN_W'(RUN_BITS);

	// ----------------------------------------------------------------
	// rotation match of the last eight bits against the repeating code
	// ----------------------------------------------------------------
	// the window may start at any phase of the code, so every rotation
	// of the effective top bits is tried
	function automatic logic rot_hit(input logic [7:0] hist,
		input logic [7:0] pat, input logic [1:0] lsel);
		int len;
		int idx;
		logic any;
		logic ok;
		len = LXB_CODE_MIN_LEN + int'(lsel);
		any = 1'b0;
		for (int k = 0; k < 8; k++) begin
			ok = (k < len);
			for (int j = 0; j < 8; j++) begin
				idx = k + j;
				if (idx >= len) idx = idx - len;
				if (idx >= len) idx = idx - len;
				if (hist[7-j] != pat[7-idx]) ok = 1'b0;
			end
			any = any | ok;
		end
		return any;
	endfunction : rot_hit

	// ----------------------------------------------------------------
	// per-channel history and run counters
	// ----------------------------------------------------------------
	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		logic [7:0] hist_r;
		logic [RUN_W-1:0] act_run_r;
		logic [RUN_W-1:0] deact_run_r;
		wire logic [7:0] hist_nxt = {hist_r[6:0], det.rx_bit[c]};
		wire logic act_now = rot_hit(hist_nxt, det.act_pattern,
			det.act_len); // [R10] [R13]
		wire logic deact_now = rot_hit(hist_nxt, det.deact_pattern,
			det.deact_len); // [R11] [R14]

		// a hit only stands while every new bit keeps the code going
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				hist_r <= '0;
				act_run_r <= '0;
				deact_run_r <= '0;
			end else if (clk_en) begin
				if (!det.det_enable) begin
					act_run_r <= '0;
					deact_run_r <= '0;
				end else if (det.rx_bit_valid[c]) begin
					hist_r <= hist_nxt;
					if (!act_now) act_run_r <= '0; // [R19]
					else if (act_run_r != RUN_MAX) act_run_r <= act_run_r + 1'b1;
					if (!deact_now) deact_run_r <= '0; // [R19]
					else if (deact_run_r != RUN_MAX)
						deact_run_r <= deact_run_r + 1'b1;
				end
			end
		end

		assign det.act_hit[c] = (act_run_r == RUN_MAX);
		assign det.deact_hit[c] = (deact_run_r == RUN_MAX);
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_det_off_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && !det.det_enable) |=> det.act_hit == '0) // [R08]
		else $error("code hit reported with the detector disabled");
	a_run_breaks: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && det.det_enable && det.rx_bit_valid[0]
		&& !g_ch[0].act_now) |=> !det.act_hit[0]) // [R19]
		else $error("activate hit held after the code was broken");

endmodule : lxb_code_detect

/* lxb_config_bank.sv */
/*
 * lxb_config_bank: expanded configuration bank of the octal line
 * interface - power-down, zero-run, violation and termination bits plus
 * the global in-band loopback configuration, status and interrupt bits.
 * Assumes the host port is already synchronous to sys_clk with one-cycle
 * read and write strobes; transmit clock pins come straight from pads.
 */
`timescale 1ns/1ns

// Functional notes
// [R01] receiver power-down bits, reset zero
// [R02] transmitter power-down bits force driver high-Z
// [R03] transmitter down if clock held low OR bit
// [R04] zero-run detect only in coded single rail
// [R05] violation bit inverted: zero enables detection
// [R06] termination bit: one selects single-ended tip
// [R07] config top two bits reset and stay zero
// [R08] config bit 5 enables loopback code detection
// [R09] config bit 4 enables automatic loopback
// [R10] activate length field picks 5 to 8 bits
// [R11] deactivate length field picks 5 to 8 bits
// [R12] loopback config is one global register
// [R13] activate pattern register, reset zero
// [R14] deactivate pattern register, reset zero
// [R15] software replicates short codes into low bits
// [R16] software selects expanded bank via pointer
// [R17] status sets on activate, clears on deactivate
// [R18] interrupt on status change, clears on read
// [R19] match only while code keeps repeating
// [R20] automatic loopback follows activate and deactivate
module lxb_config_bank import lxb_pkg::*; #(
	parameter int CHANNELS = LXB_CHANNELS,
	parameter int RUN_BITS = LXB_MATCH_RUN,
	parameter int TCLK_LOW_CYC = LXB_TCLK_LOW_CYC
) (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// host register port
	input wire logic [7:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_rdata_valid,
	// transmit clock pins
	input wire logic [7:0] tx_clock_input,
	// line coding state from the datapath
	input wire logic [7:0] single_rail_mode,
	input wire logic [7:0] hdb3_decoder_sel,
	// decoded receive bits
	input wire logic [7:0] rx_bit,
	input wire logic [7:0] rx_bit_valid,
	// per-channel controls
	output logic [7:0] rx_power_down,
	output logic [7:0] tx_power_down,
	output logic [7:0] zero_run_detect_en,
	output logic [7:0] violation_detect_en,
	output logic [7:0] single_ended_term,
	// loopback state
	output logic [7:0] loop_status,
	output logic [7:0] loop_interrupt,
	output logic [7:0] loop_engage
);
	localparam int LOW_W = $clog2(TCLK_LOW_CYC + 1);
	localparam logic [LOW_W-1:0] LOW_MAX = LOW_W'(TCLK_LOW_CYC);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] bank_ptr_r;
	logic [7:0] rx_power_down_bits_r;
	logic [7:0] tx_power_down_bits_r;
	logic [7:0] zero_run_enable_bits_r;
	logic [7:0] violation_disable_bits_r;
	logic [7:0] single_ended_select_bits_r;
	logic [7:0] loop_config_fields_r;
	logic [7:0] activate_pattern_r;
	logic [7:0] deactivate_pattern_r;
	logic [7:0] loop_status_bits_r;
	logic [7:0] loop_interrupt_mask_bits_r;
	logic [7:0] loop_interrupt_bits_r;
	logic [7:0] tclk_s1_r;
	logic [7:0] tclk_s2_r;
	logic [7:0] tclk_dead_r;
	logic [7:0] tx_pd_out_r;
	logic [7:0] zero_run_out_r;
	logic [7:0] viol_en_out_r;
	logic [7:0] loop_engage_r;
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic [7:0] rd_mux;

	lxb_det_if det_link ();

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [7:0] addr,
		input logic [7:0] off);
		return addr == off;
	endfunction : addr_hit

	// expanded offsets only answer once the pointer selects them
	wire logic exp_sel = (bank_ptr_r == LXB_BANK_EXPANDED); // [R16]
	wire logic wr_go = clk_en && host_wr;
	wire logic rd_go = clk_en && host_rd;
	wire logic wr_ptr = wr_go && addr_hit(host_addr, LXB_OFF_BANK_PTR);
	wire logic wr_rpd = wr_go && exp_sel && addr_hit(host_addr, LXB_OFF_RX_PD);
	wire logic wr_tpd = wr_go && exp_sel && addr_hit(host_addr, LXB_OFF_TX_PD);
	wire logic wr_zr = wr_go && exp_sel && addr_hit(host_addr, LXB_OFF_ZERO_RUN);
	wire logic wr_cv = wr_go && exp_sel && addr_hit(host_addr, LXB_OFF_VIOL_DIS);
	wire logic wr_trm = wr_go && exp_sel && addr_hit(host_addr, LXB_OFF_TERM_SEL);
	wire logic wr_cfg = wr_go && exp_sel && addr_hit(host_addr, LXB_OFF_LOOP_CFG);
	wire logic wr_act = wr_go && exp_sel && addr_hit(host_addr, LXB_OFF_ACT_PAT);
	wire logic wr_dea = wr_go && exp_sel
		&& addr_hit(host_addr, LXB_OFF_DEACT_PAT);
	wire logic wr_msk = wr_go && exp_sel
		&& addr_hit(host_addr, LXB_OFF_LOOP_MASK);
	wire logic rd_stat = rd_go && exp_sel
		&& addr_hit(host_addr, LXB_OFF_LOOP_STAT);

	// ----------------------------------------------------------------
	// global loopback fields
	// ----------------------------------------------------------------
	// one register shared by all channels
	wire logic det_en = loop_config_fields_r[LXB_CFG_DET_BIT]; // [R08] [R12]
	wire logic auto_en = loop_config_fields_r[LXB_CFG_AUTO_BIT]; // [R09]
	wire logic [1:0] act_len =
		loop_config_fields_r[LXB_CFG_ALEN_LSB +: 2]; // [R10]
	wire logic [1:0] deact_len =
		loop_config_fields_r[LXB_CFG_DLEN_LSB +: 2]; // [R11]

	assign det_link.det_enable = det_en;
	assign det_link.act_pattern = activate_pattern_r;
	assign det_link.deact_pattern = deactivate_pattern_r;
	assign det_link.act_len = act_len;
	assign det_link.deact_len = deact_len;
	assign det_link.rx_bit = rx_bit;
	assign det_link.rx_bit_valid = rx_bit_valid;

	lxb_code_detect #(
		.CHANNELS(CHANNELS),
		.RUN_BITS(RUN_BITS)
	) u_detect (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.det(det_link.det)
	);

	// ----------------------------------------------------------------
	// status and interrupt next values
	// ----------------------------------------------------------------
	// activate beats deactivate in the same cycle; disabled means normal
	wire logic [7:0] loop_status_nxt = det_en ?
		((loop_status_bits_r & ~det_link.deact_hit) | det_link.act_hit)
		: LXB_RST_BYTE; // [R17]
	wire logic [7:0] status_change = (loop_status_nxt ^ loop_status_bits_r)
		& loop_interrupt_mask_bits_r & {8{det_en}}; // [R18]
	// a change in the clearing cycle is kept: the set wins
	wire logic [7:0] loop_interrupt_nxt =
		(loop_interrupt_bits_r & ~{8{rd_stat}}) | status_change; // [R18]
	wire logic [7:0] loop_engage_nxt =
		auto_en ? loop_status_nxt : LXB_RST_BYTE; // [R20]
	wire logic [7:0] coded_single = single_rail_mode & hdb3_decoder_sel;

	// ----------------------------------------------------------------
	// read selection
	// ----------------------------------------------------------------
	// unmapped offsets and a primary-bank pointer read back zero
	always_comb begin
		rd_mux = LXB_RST_BYTE;
		if (addr_hit(host_addr, LXB_OFF_BANK_PTR)) rd_mux = bank_ptr_r;
		else if (exp_sel) begin
			unique case (host_addr)
				LXB_OFF_RX_PD: rd_mux = rx_power_down_bits_r;
				LXB_OFF_TX_PD: rd_mux = tx_power_down_bits_r;
				LXB_OFF_ZERO_RUN: rd_mux = zero_run_enable_bits_r;
				LXB_OFF_VIOL_DIS: rd_mux = violation_disable_bits_r;
				LXB_OFF_TERM_SEL: rd_mux = single_ended_select_bits_r;
				LXB_OFF_LOOP_CFG: rd_mux = loop_config_fields_r;
				LXB_OFF_ACT_PAT: rd_mux = activate_pattern_r;
				LXB_OFF_DEACT_PAT: rd_mux = deactivate_pattern_r;
				LXB_OFF_LOOP_STAT: rd_mux = loop_status_bits_r;
				LXB_OFF_LOOP_MASK: rd_mux = loop_interrupt_mask_bits_r;
				LXB_OFF_LOOP_INT: rd_mux = loop_interrupt_bits_r;
				default: rd_mux = LXB_RST_BYTE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// host-written registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_ptr_r <= LXB_BANK_PRIMARY;
			rx_power_down_bits_r <= LXB_RST_BYTE; // [R01]
			tx_power_down_bits_r <= LXB_RST_BYTE; // [R02]
			zero_run_enable_bits_r <= LXB_RST_BYTE; // [R04]
			violation_disable_bits_r <= LXB_RST_BYTE; // [R05]
			single_ended_select_bits_r <= LXB_RST_BYTE; // [R06]
			loop_config_fields_r <= LXB_RST_BYTE; // [R07]
			activate_pattern_r <= LXB_RST_BYTE; // [R13]
			deactivate_pattern_r <= LXB_RST_BYTE; // [R14]
			loop_interrupt_mask_bits_r <= LXB_RST_BYTE;
		end else begin
			if (wr_ptr) bank_ptr_r <= host_wdata;
			if (wr_rpd) rx_power_down_bits_r <= host_wdata; // [R01]
			if (wr_tpd) tx_power_down_bits_r <= host_wdata; // [R02]
			if (wr_zr) zero_run_enable_bits_r <= host_wdata;
			if (wr_cv) violation_disable_bits_r <= host_wdata;
			if (wr_trm) single_ended_select_bits_r <= host_wdata; // [R06]
			// reserved top bits are never stored
			if (wr_cfg) loop_config_fields_r <= host_wdata & LXB_CFG_WR_MASK; // [R07]
			// short codes use only the top bits; the low bits are never compared
			if (wr_act) activate_pattern_r <= host_wdata; // [R13] [R15]
			if (wr_dea) deactivate_pattern_r <= host_wdata; // [R14] [R15]
			if (wr_msk) loop_interrupt_mask_bits_r <= host_wdata;
		end
	end

	// ----------------------------------------------------------------
	// loopback status, interrupt and engage
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_status_bits_r <= LXB_RST_BYTE;
			loop_interrupt_bits_r <= LXB_RST_BYTE;
			loop_engage_r <= LXB_RST_BYTE;
		end else if (clk_en) begin
			loop_status_bits_r <= loop_status_nxt; // [R17]
			loop_interrupt_bits_r <= loop_interrupt_nxt; // [R18]
			loop_engage_r <= loop_engage_nxt; // [R09] [R20]
		end
	end

	// ----------------------------------------------------------------
	// transmit clock watch
	// ----------------------------------------------------------------
	// a toggling clock is low only half a period, so power-down waits
	// for a low that outlasts any real clock phase
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tclk_s1_r <= '1;
			tclk_s2_r <= '1;
		end else if (clk_en) begin
			tclk_s1_r <= tx_clock_input;
			tclk_s2_r <= tclk_s1_r;
		end
	end

	for (genvar c = 0; c < CHANNELS; c++) begin : g_tclk
		logic [LOW_W-1:0] low_cnt_r;
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				low_cnt_r <= '0;
				tclk_dead_r[c] <= 1'b0;
			end else if (clk_en) begin
				if (tclk_s2_r[c]) low_cnt_r <= '0;
				else if (low_cnt_r != LOW_MAX) low_cnt_r <= low_cnt_r + 1'b1;
				tclk_dead_r[c] <= (low_cnt_r == LOW_MAX) && !tclk_s2_r[c];
			end
		end
	end

	// ----------------------------------------------------------------
	// registered control outputs and read answer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_pd_out_r <= LXB_RST_BYTE;
			zero_run_out_r <= LXB_RST_BYTE;
			viol_en_out_r <= LXB_RST_BYTE;
			rdata_r <= LXB_RST_BYTE;
			rvalid_r <= 1'b0;
		end else if (clk_en) begin
			tx_pd_out_r <= tx_power_down_bits_r | tclk_dead_r; // [R02] [R03]
			zero_run_out_r <= zero_run_enable_bits_r & coded_single; // [R04]
			viol_en_out_r <= ~violation_disable_bits_r & coded_single; // [R05]
			rvalid_r <= host_rd;
			if (host_rd) rdata_r <= rd_mux;
		end
	end

	assign host_rdata = rdata_r;
	assign host_rdata_valid = rvalid_r;
	assign rx_power_down = rx_power_down_bits_r; // [R01]
	assign tx_power_down = tx_pd_out_r;
	assign zero_run_detect_en = zero_run_out_r;
	assign violation_detect_en = viol_en_out_r;
	assign single_ended_term = single_ended_select_bits_r; // [R06]
	assign loop_status = loop_status_bits_r;
	assign loop_interrupt = loop_interrupt_bits_r;
	assign loop_engage = loop_engage_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_act_up;
		clk_en && det_en && det_link.act_hit[0] && !loop_status_bits_r[0];
	endsequence
	sequence s_status_flip;
		s_act_up and loop_interrupt_mask_bits_r[0];
	endsequence

	a_rx_pd_write: assert property (wr_rpd |=> ##1 // [R01]
		rx_power_down == $past(host_wdata, 2))
		else $error("receiver power-down did not take the written byte");
	a_tx_pd_force: assert property ((clk_en && wr_tpd) ##1 clk_en // [R02]
		|=> (tx_power_down & $past(host_wdata, 2)) == $past(host_wdata, 2))
		else $error("transmitter power-down bit not on the output");
	a_tclk_low_pd: assert property ((clk_en && tclk_dead_r[0]) // [R03]
		|=> tx_power_down[0])
		else $error("held-low transmit clock did not power down");
	a_zero_run_gate: assert property (clk_en |=> // [R04]
		(zero_run_detect_en & ~$past(coded_single)) == '0)
		else $error("zero-run detect enabled outside coded single rail");
	a_viol_sense: assert property ((clk_en && coded_single[0] // [R05]
		&& !violation_disable_bits_r[0]) |=> violation_detect_en[0])
		else $error("violation detect off while its bit is zero");
	a_term_write: assert property (wr_trm |=> // [R06]
		single_ended_term == $past(host_wdata))
		else $error("termination select did not take the written byte");
	a_cfg_reserved: assert property ((rd_go && exp_sel // [R07]
		&& addr_hit(host_addr, LXB_OFF_LOOP_CFG)) |=> host_rdata[7:6] == '0)
		else $error("reserved loopback config bits read nonzero");
	a_status_off: assert property ((clk_en && !det_en) |=> // [R08] [R17]
		loop_status == '0)
		else $error("loopback status held with the detector disabled");
	a_int_on_flip: assert property (s_status_flip |=> // [R18]
		loop_interrupt[0] && loop_status[0])
		else $error("status change did not raise the loopback interrupt");
	a_int_rd_clear: assert property ((rd_stat && status_change == '0) // [R18]
		|=> loop_interrupt == '0)
		else $error("loopback interrupt survived a status read");
	a_auto_engage: assert property ((s_act_up and auto_en) |=> // [R09] [R20]
		loop_engage[0])
		else $error("automatic loopback did not engage on activate code");

endmodule : lxb_config_bank

/* lxb_host_model.sv */
/*
 * lxb_host_model: host processor on the register port, with write and
 * read tasks. Assumes the bench calls one task at a time.
 */
`timescale 1ns/1ns
module lxb_host_model import lxb_pkg::*; (
	// host register port
	input wire logic sys_clk,
	output logic [7:0] host_addr,
	output logic host_wr,
	output logic host_rd,
	output logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata
);
	initial begin
		host_addr = 8'h00;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_wdata = 8'h00;
	end

	// one-cycle strobe; released data inverted so stale data never passes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge sys_clk);
		host_wr <= 1'b0;
		host_wdata <= ~d;
	endtask : wr

	// answer lands one edge after the read edge, taken at the next edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge sys_clk);
		host_rd <= 1'b0;
		@(posedge sys_clk);
		d = host_rdata;
	endtask : rd

	// expanded bank must be selected before its registers
	task automatic open_bank();
		wr(LXB_OFF_BANK_PTR, LXB_BANK_EXPANDED);
	endtask : open_bank
endmodule : lxb_host_model

/* testbench.sv */
/*
 * testbench: drives lxb_config_bank through the host model and checks
 * register bits, derived controls and loopback detection.
 * Assumes shortened RUN_BITS and TCLK_LOW_CYC overrides.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
	import lxb_pkg::*;
	logic sys_clk = 1'b0, rst_n = 1'b0, host_wr, host_rd, host_rdata_valid;
	logic [7:0] host_addr, host_wdata, host_rdata, tclk_stop = 8'h00;
	logic [7:0] tx_clock_input = 8'h00, rx_bit = 8'h00, rx_bit_valid = 8'h00;
	logic [7:0] single_rail_mode = 8'hF0, hdb3_decoder_sel = 8'h3C;
	logic [7:0] rx_power_down, tx_power_down, zero_run_detect_en;
	logic [7:0] violation_detect_en, single_ended_term, loop_status;
	logic [7:0] loop_interrupt, loop_engage;
	logic clk_en = 1'b1;
	int fail_count = 0, n_tests = 0, cycles = 0, n_valid = 0;

	lxb_host_model i_host (.sys_clk(sys_clk), .host_addr(host_addr),
		.host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
		.host_rdata(host_rdata));
	lxb_config_bank #(.RUN_BITS(10), .TCLK_LOW_CYC(4)) i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
		.host_wdata(host_wdata), .host_rdata(host_rdata),
		.host_rdata_valid(host_rdata_valid),
		.tx_clock_input(tx_clock_input), .single_rail_mode(single_rail_mode),
		.hdb3_decoder_sel(hdb3_decoder_sel), .rx_bit(rx_bit),
		.rx_bit_valid(rx_bit_valid), .rx_power_down(rx_power_down),
		.tx_power_down(tx_power_down), .zero_run_detect_en(zero_run_detect_en),
		.violation_detect_en(violation_detect_en),
		.single_ended_term(single_ended_term), .loop_status(loop_status),
		.loop_interrupt(loop_interrupt), .loop_engage(loop_engage));

	// clock, running transmit clocks (stopped ones sit low), hang guard
	initial forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		tx_clock_input <= ~tx_clock_input & ~tclk_stop;
		cycles++;
		if (host_rdata_valid) n_valid++;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// closed bank refuses, then reset value and readback of offsets 03 to 0A
	task automatic t_regs();
		logic [7:0] d, v;
		i_host.wr(LXB_OFF_RX_PD, 8'hFF);
		i_host.rd(LXB_OFF_RX_PD, d);
		`CHK("closed bank", 8'h00, d)
		i_host.open_bank();
		for (int a = 3; a <= 10; a++) begin
			v = {a[3:0], ~a[3:0]};
			i_host.rd(a[7:0], d);
			`CHK("reset value", 8'h00, d)
			i_host.wr(a[7:0], v);
			i_host.rd(a[7:0], d);
			`CHK("readback", (a == 8) ? (v & 8'h3F) : v, d)
		end
		// a write while the enable is low must leave the bank frozen
		@(posedge sys_clk) clk_en <= 1'b0;
		i_host.wr(LXB_OFF_RX_PD, 8'h55);
		@(posedge sys_clk) clk_en <= 1'b1;
		`CHK("frozen", 8'h3C, rx_power_down)
		`CHK("rx down", 8'h3C, rx_power_down)
		`CHK("tx down", 8'h4B, tx_power_down)
		`CHK("zero run", 8'h10, zero_run_detect_en)
		`CHK("violation", 8'h10, violation_detect_en)
		`CHK("term", 8'h78, single_ended_term)
	endtask : t_regs

	// a held-low clock powers down on its own, and releases again
	task automatic t_tclk();
		@(posedge sys_clk) tclk_stop <= 8'h81;
		repeat (12) @(posedge sys_clk);
		#1 `CHK("clock low", 8'hCB, tx_power_down)
		`CHK("read strobes", 17, n_valid)
		@(posedge sys_clk) tclk_stop <= 8'h00;
		repeat (12) @(posedge sys_clk);
		#1 `CHK("clock back", 8'h4B, tx_power_down)
	endtask : t_tclk

	// forty bits, oldest first, on channel 2 only
	task automatic send(input logic [39:0] s);
		for (int i = 39; i >= 0; i--) begin
			@(posedge sys_clk);
			rx_bit <= {8{s[i]}};
			rx_bit_valid <= 8'h04;
			@(posedge sys_clk);
			rx_bit_valid <= 8'h00;
		end
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : send

	task automatic t_loop();
		logic [7:0] d;
		i_host.wr(LXB_OFF_ACT_PAT, 8'hC6);
		i_host.wr(LXB_OFF_DEACT_PAT, 8'h0F);
		i_host.wr(LXB_OFF_LOOP_MASK, 8'h04);
		i_host.wr(LXB_OFF_LOOP_CFG, 8'h33);
		send(40'hC6318C6318);
		`CHK("status on", 8'h04, loop_status)
		`CHK("engage", 8'h04, loop_engage)
		`CHK("irq set", 8'h04, loop_interrupt)
		i_host.rd(LXB_OFF_LOOP_STAT, d);
		`CHK("status read", 8'h04, d)
		`CHK("irq clear", 8'h00, loop_interrupt)
		send(40'h0F0F0F0F0F);
		`CHK("status off", 8'h00, loop_status)
		`CHK("release", 8'h00, loop_engage)
		i_host.wr(LXB_OFF_LOOP_CFG, 8'h23);
		send(40'hC6318C6318);
		`CHK("manual", 8'h00, loop_engage)
		`CHK("status again", 8'h04, loop_status)
	endtask : t_loop

	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		$display("registers done");
		t_tclk();
		$display("transmit clock done");
		t_loop();
		$display("loopback done");
		final_report();
	end
endmodule : testbench
